// ===== tb.sv
// Self-checking testbench of the Timer B mode-control block.
// Assumes the header, package, design and checker are compiled first.
`timescale 1ns/1ps
`include "timer_b_mode_consts.svh"
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  timer_b_mode_pkg::bus_req_t req = '0;
  timer_b_mode_pkg::mode_t mode_a = '0;
  logic concat = 1'b0;
  logic en = 1'b1;
  logic stall = 1'b0;
  logic ce = 1'b1;
  logic [1:0] sel = 2'h0;
  logic [2:0] ev = 3'h0;
  logic lvl = 1'b0;
  logic [31:0] rdata;
  logic [15:0] mval;
  logic [15:0] lval;
  logic [7:0] pval;
  logic [1:0] tmode;
  logic lstb, cup, pwm, etime, plvl, irq;
  logic [7:0] lpre;
  logic adc, dma;
  int errors = 0;
  int checks_done = 0;
  int strobes = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (lstb === 1'b1) strobes <= strobes + 1;
  timer_b_mode_update_control #(.VAL_W(16)) u_timer_b_mode_update_control (
    .CLK(clk), .NRST(nrst), .CE(ce), .BUS_REQ(req), .RDATA(rdata), .CONCAT(concat), .MODE_A(mode_a),
    .HALF_ENABLE(en), .HALF_STALL(stall), .PWM_EVENT_EDGE_SELECT(sel), .OUTPUT_TRIGGER_ENABLE(1'b1),
    .CAPTURE_DMA_EVENT_ENABLE(1'b1), .TIMEOUT(ev[0]), .MATCH_HIT(ev[1]), .CAPTURE_EVENT(ev[2]),
    .PWM_LEVEL(lvl), .MATCH_VALUE(mval), .PRESCALE_VALUE(pval), .LOAD_STROBE(lstb), .LOAD_VALUE(lval),
    .LOAD_PRESCALE(lpre), .COUNT_UP(cup), .PWM_MODE(pwm), .TIMER_MODE(tmode), .EDGE_TIME(etime),
    .PIN_RELOAD_LEVEL(plvl), .ADC_TRIGGER(adc), .DMA_TRIGGER(dma), .IRQ(irq)
  );
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test;
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd
  task pulse(input logic [2:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 3'h0;
  endtask : pulse
  task load_seen(input logic [15:0] v);
    int k;
    #1;
    for (k = 0; k < 8 && lstb !== 1'b1; k++)
      tick(1);
    if (lstb !== 1'b1)
    begin
      errors++;
      end_of_test;
    end
    else
      chk(32'({lpre, lval}), 32'({8'h5a, v}));
  endtask : load_seen
  function logic [31:0] st();
    return {26'h0, pwm, cup, plvl, etime, tmode};
  endfunction : st
  initial
  begin
    int i;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(`TBM_OFF_MODE, 32'h0);
    wr(8'h7c, 32'hffff_ffff);
    rd(8'h7c, 32'h0);
    wr(`TBM_OFF_MODE, 32'hffff_ffff);
    tick(1);
    chk(st(), 32'h2f);
    rd(`TBM_OFF_MODE, 32'h0000_0f3f);
    for (i = 1; i < 4; i++)
    begin
      wr(`TBM_OFF_MODE, 32'h10 | i);
      tick(1);
      chk(st(), 32'h10 | i);
    end
    @(posedge clk);
    ce <= 1'b0;
    wr(`TBM_OFF_MODE, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    rd(`TBM_OFF_MODE, 32'h0000_0013);
    @(posedge clk);
    concat <= 1'b1;
    mode_a <= 32'h0000_0809;
    wr(`TBM_OFF_MODE, 32'h0000_0012);
    tick(1);
    chk(st(), 32'h29);
    @(posedge clk);
    mode_a <= 32'h0000_0002;
    stall <= 1'b1;
    wr(`TBM_OFF_MATCH_SHADOW, 32'h1234);
    wr(`TBM_OFF_PRESCALE_SHADOW, 32'h5a);
    tick(2);
    chk(32'({pval, mval}), 32'h5a_1234);
    @(posedge clk);
    stall <= 1'b0;
    mode_a <= 32'h0000_0402;
    wr(`TBM_OFF_MATCH_SHADOW, 32'h5678);
    tick(3);
    chk(32'(mval), 32'h1234);
    pulse(3'h1);
    tick(1);
    chk(32'(mval), 32'h5678);
    @(posedge clk);
    en <= 1'b0;
    wr(`TBM_OFF_MATCH_SHADOW, 32'h9abc);
    pulse(3'h1);
    tick(2);
    chk(32'(mval), 32'h5678);
    @(posedge clk);
    en <= 1'b1;
    tick(3);
    chk(32'(mval), 32'h9abc);
    @(posedge clk);
    mode_a <= 32'h0000_0102;
    wr(`TBM_OFF_LOAD_SHADOW, 32'h0bcd);
    i = strobes;
    tick(3);
    chk(strobes, i);
    pulse(3'h1);
    load_seen(16'h0bcd);
    @(posedge clk);
    mode_a <= 32'h0000_0112;
    wr(`TBM_OFF_LOAD_SHADOW, 32'h0222);
    load_seen(16'h0222);
    @(posedge clk);
    en <= 1'b0;
    mode_a <= 32'h0000_0102;
    wr(`TBM_OFF_LOAD_SHADOW, 32'h0333);
    i = strobes;
    pulse(3'h1);
    tick(2);
    chk(strobes, i);
    @(posedge clk);
    en <= 1'b1;
    load_seen(16'h0333);
    @(posedge clk);
    mode_a <= 32'h0000_022a;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      sel <= i[1:0];
      lvl <= 1'b1;
      tick(2);
      rd(`TBM_OFF_IRQ_STATUS, 32'(i == 0 || i == 3));
      @(posedge clk);
      lvl <= 1'b0;
      tick(2);
      rd(`TBM_OFF_IRQ_STATUS, 32'(i == 1 || i == 3));
    end
    pulse(3'h4);
    tick(0);
    chk(32'({adc, dma}), 32'h3);
    rd(`TBM_OFF_IRQ_STATUS, 32'h0000_000c);
    @(posedge clk);
    mode_a <= 32'h0000_0022;
    pulse(3'h2);
    tick(0);
    chk(32'({adc, dma}), 32'h1);
    rd(`TBM_OFF_IRQ_STATUS, 32'h0000_000a);
    @(posedge clk);
    mode_a <= 32'h0000_0002;
    pulse(3'h2);
    tick(0);
    chk(32'({adc, dma}), 32'h0);
    rd(`TBM_OFF_IRQ_STATUS, 32'h0);
    @(posedge clk);
    mode_a <= 32'h0000_022a;
    wr(`TBM_OFF_IRQ_MASK, 32'h1);
    pulse(3'h4);
    tick(2);
    chk(32'(irq), 32'h0);
    @(posedge clk);
    lvl <= 1'b1;
    tick(3);
    chk(32'(irq), 32'h1);
    rd(`TBM_OFF_IRQ_STATUS, 32'h0000_000d);
    tick(1);
    chk(32'(irq), 32'h0);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`TBM_OFF_MODE, 32'h0);
    chk(st(), 32'h22);
    end_of_test;
  end
endmodule : tb

// ===== timer_b_mode_consts.svh
// Holds offsets, field positions, reset values and encodings of the Timer B mode-control block.
// Assumes inclusion by bare name from the design files.
`ifndef TIMER_B_MODE_CONSTS_SVH
`define TIMER_B_MODE_CONSTS_SVH
`define TBM_OFF_MODE 8'h08
`define TBM_OFF_IRQ_STATUS 8'h40
`define TBM_OFF_IRQ_MASK 8'h44
`define TBM_OFF_MATCH_SHADOW 8'h48
`define TBM_OFF_PRESCALE_SHADOW 8'h4c
`define TBM_OFF_LOAD_SHADOW 8'h50
`define TBM_OFF_STATE 8'h54
`define TBM_MODE_RESET 32'h0000_0000
`define TBM_MODE_WMASK 32'h0000_0f3f
`define TBM_BIT_PLO 11
`define TBM_BIT_MRSU 10
`define TBM_BIT_PWMIE 9
`define TBM_BIT_ILD 8
`define TBM_BIT_MIE 5
`define TBM_BIT_CDIR 4
`define TBM_BIT_AMS 3
`define TBM_BIT_CMR 2
`define TBM_TMR_ONESHOT 2'h1
`define TBM_TMR_PERIODIC 2'h2
`define TBM_TMR_CAPTURE 2'h3
`define TBM_EV_POS 2'h0
`define TBM_EV_NEG 2'h1
`define TBM_EV_BOTH 2'h3
`define TBM_IRQ_PWM 0
`define TBM_IRQ_MATCH 1
`define TBM_IRQ_ADC 2
`define TBM_IRQ_DMA 3
`define TBM_IRQ_WIDTH 4
`endif

// ===== timer_b_mode_pkg.sv
// Holds the types of the Timer B mode-control block.
// Assumes the constants header is compiled alongside.
package timer_b_mode_pkg;
  typedef struct packed {
    logic [19:0] rsvd_hi;
    logic pwm_legacy_polarity;
    logic match_update_timing;
    logic pwm_edge_irq_enable;
    logic interval_load_timing;
    logic [1:0] rsvd_lo;
    logic match_irq_enable;
    logic count_direction;
    logic alternate_mode_select;
    logic capture_mode_select;
    logic [1:0] timer_mode_field;
  } mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef enum logic [1:0] {PEND_NONE, PEND_CYCLE, PEND_TIMEOUT, PEND_ENABLE} pend_t;
endpackage : timer_b_mode_pkg

// ===== timer_b_mode_sva.sv
// Checker of the Timer B mode-control block.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/1ps
`include "timer_b_mode_consts.svh"
module timer_b_mode_sva #(
  parameter int VAL_W = 16
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire timer_b_mode_pkg::bus_req_t BUS_REQ,
  input wire logic [31:0] RDATA,
  input wire logic CONCAT,
  input wire timer_b_mode_pkg::mode_t MODE_A,
  input wire logic OUTPUT_TRIGGER_ENABLE,
  input wire logic CAPTURE_DMA_EVENT_ENABLE,
  input wire logic MATCH_HIT,
  input wire logic CAPTURE_EVENT,
  input wire logic [VAL_W-1:0] MATCH_VALUE,
  input wire logic COUNT_UP,
  input wire logic PWM_MODE,
  input wire logic [1:0] TIMER_MODE,
  input wire logic PIN_RELOAD_LEVEL,
  input wire logic ADC_TRIGGER,
  input wire logic DMA_TRIGGER,
  input wire logic LOAD_STROBE,
  input wire logic IRQ
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST || !CE);
  property p_rd_idle;
    !BUS_REQ.rd |=> RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("Read data not zero outside a read answer.");
  property p_rsvd;
    BUS_REQ.rd && BUS_REQ.addr == `TBM_OFF_MODE |=> RDATA[31:12] == 20'h0 && RDATA[7:6] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved mode bits read nonzero.");
  property p_pwm_down;
    PWM_MODE |-> !COUNT_UP;
  endproperty
  a_pwm_down: assert property (p_pwm_down) else $error("PWM mode counts up.");
  property p_concat;
    CONCAT |=> TIMER_MODE == $past(MODE_A.timer_mode_field) && PWM_MODE == $past(MODE_A.alternate_mode_select);
  endproperty
  a_concat: assert property (p_concat) else $error("Concatenated mode not taken from first half.");
  property p_pin;
    CONCAT && MODE_A.alternate_mode_select |=> PIN_RELOAD_LEVEL == $past(MODE_A.pwm_legacy_polarity);
  endproperty
  a_pin: assert property (p_pin) else $error("Reload pin level wrong.");
  sequence s_cap;
    CONCAT && MODE_A.alternate_mode_select && MODE_A.pwm_edge_irq_enable && CAPTURE_EVENT;
  endsequence
  property p_adc;
    s_cap ##0 OUTPUT_TRIGGER_ENABLE |=> ADC_TRIGGER;
  endproperty
  a_adc: assert property (p_adc) else $error("Capture gave no ADC trigger.");
  property p_dma;
    s_cap ##0 CAPTURE_DMA_EVENT_ENABLE |=> DMA_TRIGGER;
  endproperty
  a_dma: assert property (p_dma) else $error("Capture gave no DMA trigger.");
  property p_no_mdma;
    CONCAT && !MODE_A.match_irq_enable && MATCH_HIT && !CAPTURE_EVENT |=> !DMA_TRIGGER;
  endproperty
  a_no_mdma: assert property (p_no_mdma) else $error("Masked match gave a DMA trigger.");
  property p_match_now;
    CONCAT && !MODE_A.match_update_timing && BUS_REQ.wr && BUS_REQ.addr == `TBM_OFF_MATCH_SHADOW ##1 !BUS_REQ.wr
      |=> MATCH_VALUE == $past(BUS_REQ.wdata[VAL_W-1:0], 2);
  endproperty
  a_match_now: assert property (p_match_now) else $error("Match value not applied next cycle.");
  c_adc: cover property (ADC_TRIGGER);
  c_load: cover property (LOAD_STROBE);
  c_irq: cover property (IRQ);
endmodule : timer_b_mode_sva
bind timer_b_mode_update_control timer_b_mode_sva #(.VAL_W(VAL_W)) u_timer_b_mode_sva (
  .CLK(CLK), .NRST(NRST), .CE(CE), .BUS_REQ(BUS_REQ), .RDATA(RDATA), .CONCAT(CONCAT), .MODE_A(MODE_A),
  .OUTPUT_TRIGGER_ENABLE(OUTPUT_TRIGGER_ENABLE), .CAPTURE_DMA_EVENT_ENABLE(CAPTURE_DMA_EVENT_ENABLE),
  .MATCH_HIT(MATCH_HIT), .CAPTURE_EVENT(CAPTURE_EVENT), .MATCH_VALUE(MATCH_VALUE), .COUNT_UP(COUNT_UP),
  .PWM_MODE(PWM_MODE), .TIMER_MODE(TIMER_MODE), .PIN_RELOAD_LEVEL(PIN_RELOAD_LEVEL), .ADC_TRIGGER(ADC_TRIGGER),
  .DMA_TRIGGER(DMA_TRIGGER), .LOAD_STROBE(LOAD_STROBE), .IRQ(IRQ)
);

// ===== timer_b_mode_update_control.sv
// Holds the Timer B mode register, the shadow-update timing of match, prescale and load, and the event logic.
// Assumes the counter datapath supplies timeout, match, capture and PWM level on CLK, and reads the outputs.
//
// Contract
// - Concatenated halves use the first-half mode register for both; second ignored.
// - PWM mode: legacy-polarity bit sets pin level at reload after zero.
// - Match-update bit: 0 apply match/prescale next cycle, 1 at timeout.
// - Match-update set while disabled: pending match loads when half becomes enabled.
// - While stalled, pending match values still transfer per match-update bit.
// - PWM interrupt enable raises interrupt on selected PWM output edges.
// - With PWM interrupt enable, capture triggers ADC and DMA when enabled.
// - Interval-load bit ignored counting up; applies while enabled and running.
// - Interval-load 0 copies load next cycle, 1 at next timeout.
// - Interval-load set while disabled: counter and snapshot update upon enabling.
// - While stalled, counter and snapshot update per interval-load bit.
// - Match interrupt enable 0 blocks match interrupt and DMA; 1 raises interrupt and DMA in one-shot or periodic compare mode only.
// - Count-direction 0 down, 1 up from zero; PWM always counts down.
// - Alternate mode 0 capture/compare, 1 PWM; capture mode 0 count, 1 time.
// - Timer-mode field 1 one-shot, 2 periodic, 3 capture; 0 reserved.
`timescale 1ns/1ps
`include "timer_b_mode_consts.svh"
module timer_b_mode_update_control #(
  parameter int VAL_W = 16
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire timer_b_mode_pkg::bus_req_t BUS_REQ,
  output logic [31:0] RDATA,
  input wire logic CONCAT,
  input wire timer_b_mode_pkg::mode_t MODE_A,
  input wire logic HALF_ENABLE,
  input wire logic HALF_STALL,
  input wire logic [1:0] PWM_EVENT_EDGE_SELECT,
  input wire logic OUTPUT_TRIGGER_ENABLE,
  input wire logic CAPTURE_DMA_EVENT_ENABLE,
  input wire logic TIMEOUT,
  input wire logic MATCH_HIT,
  input wire logic CAPTURE_EVENT,
  input wire logic PWM_LEVEL,
  output logic [VAL_W-1:0] MATCH_VALUE,
  output logic [7:0] PRESCALE_VALUE,
  output logic LOAD_STROBE,
  output logic [VAL_W-1:0] LOAD_VALUE,
  output logic [7:0] LOAD_PRESCALE,
  output logic COUNT_UP,
  output logic PWM_MODE,
  output logic [1:0] TIMER_MODE,
  output logic EDGE_TIME,
  output logic PIN_RELOAD_LEVEL,
  output logic ADC_TRIGGER,
  output logic DMA_TRIGGER,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------
  timer_b_mode_pkg::mode_t mode_b_ff;
  timer_b_mode_pkg::mode_t eff;
  timer_b_mode_pkg::pend_t match_pend_ff;
  timer_b_mode_pkg::pend_t load_pend_ff;
  logic [VAL_W-1:0] match_sh_ff;
  logic [7:0] pre_sh_ff;
  logic [VAL_W-1:0] load_sh_ff;
  logic [`TBM_IRQ_WIDTH-1:0] irq_status_ff;
  logic [`TBM_IRQ_WIDTH-1:0] irq_mask_ff;
  logic [`TBM_IRQ_WIDTH-1:0] events;
  logic pwm_prev_ff;
  logic enable_prev_ff;
  logic wr_mode;
  logic wr_match;
  logic wr_pre;
  logic wr_load;
  logic rd_status;
  logic is_pwm;
  logic rise;
  logic fall;
  logic pwm_edge;
  logic enable_rise;

  function automatic timer_b_mode_pkg::pend_t pend_on_write(input logic timing, input logic enabled);
    if (!enabled && timing)
    begin
      return timer_b_mode_pkg::PEND_ENABLE;
    end
    return timing ? timer_b_mode_pkg::PEND_TIMEOUT : timer_b_mode_pkg::PEND_CYCLE;
  endfunction : pend_on_write

  function automatic logic pend_fire(input timer_b_mode_pkg::pend_t p, input logic tmo, input logic en_rise);
    logic f;
    f = 1'b0;
    unique case (p)
      timer_b_mode_pkg::PEND_NONE: f = 1'b0;
      timer_b_mode_pkg::PEND_CYCLE: f = 1'b1;
      timer_b_mode_pkg::PEND_TIMEOUT: f = tmo;
      timer_b_mode_pkg::PEND_ENABLE: f = en_rise;
    endcase
    return f;
  endfunction : pend_fire

  assign wr_mode = BUS_REQ.wr && (BUS_REQ.addr == `TBM_OFF_MODE);
  assign wr_match = BUS_REQ.wr && (BUS_REQ.addr == `TBM_OFF_MATCH_SHADOW);
  assign wr_pre = BUS_REQ.wr && (BUS_REQ.addr == `TBM_OFF_PRESCALE_SHADOW);
  assign wr_load = BUS_REQ.wr && (BUS_REQ.addr == `TBM_OFF_LOAD_SHADOW);
  assign rd_status = BUS_REQ.rd && (BUS_REQ.addr == `TBM_OFF_IRQ_STATUS);

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      mode_b_ff <= timer_b_mode_pkg::mode_t'(`TBM_MODE_RESET);
    end
    else if (CE && wr_mode)
    begin
      mode_b_ff <= timer_b_mode_pkg::mode_t'(BUS_REQ.wdata & `TBM_MODE_WMASK);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      irq_mask_ff <= '0;
    end
    else if (CE && BUS_REQ.wr && (BUS_REQ.addr == `TBM_OFF_IRQ_MASK))
    begin
      irq_mask_ff <= BUS_REQ.wdata[`TBM_IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      RDATA <= 32'h0000_0000;
    end
    else if (CE)
    begin
      RDATA <= 32'h0000_0000;
      if (BUS_REQ.rd)
      begin
        unique case (BUS_REQ.addr)
          `TBM_OFF_MODE: RDATA <= mode_b_ff & `TBM_MODE_WMASK;
          `TBM_OFF_IRQ_STATUS: RDATA <= 32'(irq_status_ff);
          `TBM_OFF_IRQ_MASK: RDATA <= 32'(irq_mask_ff);
          `TBM_OFF_MATCH_SHADOW: RDATA <= 32'(match_sh_ff);
          `TBM_OFF_PRESCALE_SHADOW: RDATA <= 32'(pre_sh_ff);
          `TBM_OFF_LOAD_SHADOW: RDATA <= 32'(load_sh_ff);
          `TBM_OFF_STATE: RDATA <= {28'h0000000, load_pend_ff, match_pend_ff};
          default: RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Effective mode.
  // ----------------------------------------------------------------
  assign eff = CONCAT ? MODE_A : mode_b_ff;
  assign is_pwm = eff.alternate_mode_select;
  assign enable_rise = HALF_ENABLE && !enable_prev_ff;

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      COUNT_UP <= 1'b0;
      PWM_MODE <= 1'b0;
      TIMER_MODE <= 2'h0;
      EDGE_TIME <= 1'b0;
      PIN_RELOAD_LEVEL <= 1'b0;
      enable_prev_ff <= 1'b0;
      pwm_prev_ff <= 1'b0;
    end
    else if (CE)
    begin
      COUNT_UP <= eff.count_direction && !is_pwm;
      PWM_MODE <= is_pwm;
      TIMER_MODE <= eff.timer_mode_field;
      EDGE_TIME <= eff.capture_mode_select;
      PIN_RELOAD_LEVEL <= is_pwm && eff.pwm_legacy_polarity;
      enable_prev_ff <= HALF_ENABLE;
      pwm_prev_ff <= PWM_LEVEL;
    end
  end

  // ----------------------------------------------------------------
  // Match and prescale shadow transfer.
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      match_sh_ff <= '0;
      pre_sh_ff <= 8'h00;
      match_pend_ff <= timer_b_mode_pkg::PEND_NONE;
      MATCH_VALUE <= '0;
      PRESCALE_VALUE <= 8'h00;
    end
    else if (CE)
    begin
      if (pend_fire(match_pend_ff, TIMEOUT, enable_rise))
      begin
        MATCH_VALUE <= match_sh_ff;
        PRESCALE_VALUE <= pre_sh_ff;
        match_pend_ff <= timer_b_mode_pkg::PEND_NONE;
      end
      if (wr_match || wr_pre)
      begin
        match_pend_ff <= pend_on_write(eff.match_update_timing, HALF_ENABLE);
      end
      if (wr_match)
      begin
        match_sh_ff <= BUS_REQ.wdata[VAL_W-1:0];
      end
      if (wr_pre)
      begin
        pre_sh_ff <= BUS_REQ.wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interval load transfer.
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      load_sh_ff <= '0;
      load_pend_ff <= timer_b_mode_pkg::PEND_NONE;
      LOAD_STROBE <= 1'b0;
      LOAD_VALUE <= '0;
      LOAD_PRESCALE <= 8'h00;
    end
    else if (CE)
    begin
      LOAD_STROBE <= 1'b0;
      if (pend_fire(load_pend_ff, TIMEOUT, enable_rise))
      begin
        LOAD_STROBE <= 1'b1;
        LOAD_VALUE <= load_sh_ff;
        LOAD_PRESCALE <= pre_sh_ff;
        load_pend_ff <= timer_b_mode_pkg::PEND_NONE;
      end
      if (wr_load || wr_pre)
      begin
        // Counting up ignores the timing bit and loads on the next cycle.
        load_pend_ff <= pend_on_write(eff.interval_load_timing && !(eff.count_direction && !is_pwm),
                                      HALF_ENABLE);
      end
      if (wr_load)
      begin
        load_sh_ff <= BUS_REQ.wdata[VAL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Events, triggers and interrupt.
  // ----------------------------------------------------------------
  assign rise = PWM_LEVEL && !pwm_prev_ff;
  assign fall = !PWM_LEVEL && pwm_prev_ff;
  always_comb
  begin
    pwm_edge = 1'b0;
    unique case (PWM_EVENT_EDGE_SELECT)
      `TBM_EV_POS: pwm_edge = rise;
      `TBM_EV_NEG: pwm_edge = fall;
      `TBM_EV_BOTH: pwm_edge = rise || fall;
      default: pwm_edge = 1'b0;
    endcase
  end

  always_comb
  begin
    events = '0;
    events[`TBM_IRQ_PWM] = is_pwm && eff.pwm_edge_irq_enable && pwm_edge;
    events[`TBM_IRQ_MATCH] = eff.match_irq_enable && MATCH_HIT && !is_pwm &&
                             (eff.timer_mode_field == `TBM_TMR_ONESHOT ||
                              eff.timer_mode_field == `TBM_TMR_PERIODIC);
    events[`TBM_IRQ_ADC] = is_pwm && eff.pwm_edge_irq_enable && CAPTURE_EVENT && OUTPUT_TRIGGER_ENABLE;
    events[`TBM_IRQ_DMA] = (is_pwm && eff.pwm_edge_irq_enable && CAPTURE_EVENT && CAPTURE_DMA_EVENT_ENABLE) ||
                           events[`TBM_IRQ_MATCH];
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      irq_status_ff <= '0;
      ADC_TRIGGER <= 1'b0;
      DMA_TRIGGER <= 1'b0;
      IRQ <= 1'b0;
    end
    else if (CE)
    begin
      // A new event wins over the clear from a status read.
      irq_status_ff <= (rd_status ? '0 : irq_status_ff) | events;
      ADC_TRIGGER <= events[`TBM_IRQ_ADC];
      DMA_TRIGGER <= events[`TBM_IRQ_DMA];
      IRQ <= |(((rd_status ? '0 : irq_status_ff) | events) & irq_mask_ff);
    end
  end

endmodule : timer_b_mode_update_control
